// >>> verilog/cmp_ctrl_defs.svh
// register offsets, field positions and reset values of the comparator control block
`ifndef CMP_CTRL_DEFS_SVH
`define CMP_CTRL_DEFS_SVH

`define CMP0_CONTROL_ADDR   8'h9B
`define CMP0_MODE_ADDR      8'h9D
`define CMP0_INSEL_ADDR     8'h9F
`define CMP1_CONTROL_ADDR   8'h9A
`define CMP1_MODE_ADDR      8'h9C
`define CMP1_INSEL_ADDR     8'h9E

`define CTL_EN_BIT          7
`define CTL_OUT_BIT         6
`define CTL_RISE_BIT        5
`define CTL_FALL_BIT        4
`define MODE_RIE_BIT        5
`define MODE_FIE_BIT        4

`define CTL_RESET           8'h00
`define MODE_RESET          8'h02
`define INSEL_RESET         8'hFF
`define INSEL_FIXED_ONES    8'hCC
`define INSEL_RW_MASK       8'h33
`define MODE_RW_MASK        8'h33
`define CTL_RW_MASK         8'hBF

`endif

// >>> verilog/cmp_ctrl_pkg.sv
// types shared by the comparator control block
package cmp_ctrl_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] sel2_t;
    typedef enum logic [1:0]
    {
        RESP_FASTEST = 2'b00,
        RESP_FAST    = 2'b01,
        RESP_SLOW    = 2'b10,
        RESP_SLOWEST = 2'b11
    } resp_mode_e;
endpackage

// >>> verilog/cmp_sync.sv
// two-stage synchroniser for the raw comparator decision
`timescale 1ns/1ps
module cmp_sync
(
    input  wire logic core_clk,
    input  wire logic rst_sync_n,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r;

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            meta_r   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// >>> verilog/cmp_channel.sv
// one comparator channel: registers, edge flags, output gating
`timescale 1ns/1ps
`include "cmp_ctrl_defs.svh"
module cmp_channel
    import cmp_ctrl_pkg::*;
(
    input  wire logic  core_clk,
    input  wire logic  rst_sync_n,
    input  wire logic  raw_decision,
    input  wire logic  sync_decision,
    input  wire logic  wr_ctl,
    input  wire logic  wr_mode,
    input  wire logic  wr_insel,
    input  wire byte_t wr_data,
    output byte_t      ctl_rd,
    output byte_t      mode_rd,
    output byte_t      insel_rd,
    output logic       irq_req,
    output logic       latched_next,
    output logic       raw_gated
);
    logic  enable_r;
    logic  rise_edge_flag_r;
    logic  fall_edge_flag_r;
    sel2_t pos_hysteresis_sel_r;
    sel2_t neg_hysteresis_sel_r;
    logic  rise_irq_enable_r;
    logic  fall_irq_enable_r;
    resp_mode_e response_mode_sel_r;
    sel2_t pos_input_sel_r;
    sel2_t neg_input_sel_r;
    logic  prev_r;
    logic  rise_evt;
    logic  fall_evt;
    byte_t wr_data_q;

    // edges only count while enabled so a disabled channel sets no flag from an edge (a control write still can)
    assign rise_evt = enable_r && sync_decision && !prev_r;
    assign fall_evt = enable_r && !sync_decision && prev_r;

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            prev_r <= 1'b0;
        else
            prev_r <= sync_decision;
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            enable_r             <= 1'b0;
            pos_hysteresis_sel_r <= 2'h0;
            neg_hysteresis_sel_r <= 2'h0;
        end
        else if (wr_ctl)
        begin
            enable_r             <= wr_data[`CTL_EN_BIT];
            pos_hysteresis_sel_r <= wr_data[3:2];
            neg_hysteresis_sel_r <= wr_data[1:0];
        end
    end

    // set beats a same-cycle software clear
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            rise_edge_flag_r <= 1'b0;
            fall_edge_flag_r <= 1'b0;
        end
        else
        begin
            if (rise_evt)
                rise_edge_flag_r <= 1'b1;
            else if (wr_ctl)
                rise_edge_flag_r <= wr_data[`CTL_RISE_BIT];
            if (fall_evt)
                fall_edge_flag_r <= 1'b1;
            else if (wr_ctl)
                fall_edge_flag_r <= wr_data[`CTL_FALL_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            rise_irq_enable_r   <= 1'b0;
            fall_irq_enable_r   <= 1'b0;
            response_mode_sel_r <= RESP_SLOW;
        end
        else if (wr_mode)
        begin
            rise_irq_enable_r   <= wr_data[`MODE_RIE_BIT];
            fall_irq_enable_r   <= wr_data[`MODE_FIE_BIT];
            response_mode_sel_r <= resp_mode_e'(wr_data[1:0]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pos_input_sel_r <= 2'h3;
            neg_input_sel_r <= 2'h3;
        end
        else if (wr_insel)
        begin
            neg_input_sel_r <= wr_data[5:4];
            pos_input_sel_r <= wr_data[1:0];
        end
    end

    assign ctl_rd   = {enable_r, sync_decision, rise_edge_flag_r, fall_edge_flag_r,
                       pos_hysteresis_sel_r, neg_hysteresis_sel_r};
    assign mode_rd  = {2'b00, rise_irq_enable_r, fall_irq_enable_r, 2'b00, response_mode_sel_r};
    assign insel_rd = {2'b11, neg_input_sel_r, 2'b11, pos_input_sel_r};

    assign irq_req      = (rise_edge_flag_r && rise_irq_enable_r) ||
                          (fall_edge_flag_r && fall_irq_enable_r);
    assign latched_next = enable_r && sync_decision;
    // unclocked path: no flop, works with the clock stopped
    assign raw_gated    = enable_r && raw_decision;

    a_flag_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (rise_edge_flag_r && !(wr_ctl && !wr_data[`CTL_RISE_BIT])) |=> rise_edge_flag_r)
        else $error("rise flag dropped without clear");
    a_set_wins: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        fall_evt |=> fall_edge_flag_r)
        else $error("fall edge lost");
    a_rise_sets: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (enable_r && $rose(sync_decision)) |=> rise_edge_flag_r)
        else $error("rising edge not flagged");
    a_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        irq_req |-> ((rise_edge_flag_r && rise_irq_enable_r) || (fall_edge_flag_r && fall_irq_enable_r)))
        else $error("interrupt without enabled flag");
    a_insel_ones: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (insel_rd & `INSEL_FIXED_ONES) == `INSEL_FIXED_ONES)
        else $error("unused select bits not one");
    a_mode_zeros: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        wr_mode |=> (mode_rd == (wr_data_q & `MODE_RW_MASK)))
        else $error("mode register readback wrong");

    always_ff @(posedge core_clk)
        wr_data_q <= wr_data;
endmodule

// >>> verilog/dual_comparator_control.sv
// top of the dual comparator control: register port, sync, pin outputs
//
// Overview of operation
// - two comparators, latched and raw outputs each
// - raw output works with clock stopped
// - pin output picks synchronous or raw version
// - comparator 0 offered as reset source
// - input select: negative 5-4, positive 1-0
// - input select unused bits read one
// - disabled comparator drives its outputs low
// - two-bit response time mode field
// - hysteresis fields in control bits 3-0
// - edges set rising and falling flags
// - flags stay set until software clears
// - flag interrupts only when enabled
// - control bit 6 shows comparator state
// - control bit 7 enables the comparator
// - control resets to zero
// - mode resets to 0x02, unused read zero
`timescale 1ns/1ps
`include "cmp_ctrl_defs.svh"
module dual_comparator_control
    import cmp_ctrl_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic [7:0]      sfr_rdata,
    input  wire logic [1:0] analog_decision,
    input  wire logic [1:0] pin_async_sel,
    output logic [1:0]      latched_cmp_out,
    output logic [1:0]      raw_cmp_out,
    output logic [1:0]      pin_cmp_out,
    output logic [1:0]      cmp_irq,
    output logic            cmp0_reset_src
);
    logic       rst_s1_r;
    logic       rst_sync_n;
    logic [1:0] sync_dec;
    logic [1:0] latched_next;
    logic [1:0] raw_gated;
    logic [1:0] irq_req;
    byte_t      ctl_rd   [2];
    byte_t      mode_rd  [2];
    byte_t      insel_rd [2];
    logic [1:0] wr_ctl;
    logic [1:0] wr_mode;
    logic [1:0] wr_insel;
    byte_t      rd_mux;

    // ************************************************************
    // reset release
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_r   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_s1_r   <= 1'b1;
            rst_sync_n <= rst_s1_r;
        end
    end

    // ************************************************************
    // decode
    // ************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    assign wr_ctl[0]   = sfr_wr && hit(sfr_addr, `CMP0_CONTROL_ADDR);
    assign wr_mode[0]  = sfr_wr && hit(sfr_addr, `CMP0_MODE_ADDR);
    assign wr_insel[0] = sfr_wr && hit(sfr_addr, `CMP0_INSEL_ADDR);
    assign wr_ctl[1]   = sfr_wr && hit(sfr_addr, `CMP1_CONTROL_ADDR);
    assign wr_mode[1]  = sfr_wr && hit(sfr_addr, `CMP1_MODE_ADDR);
    assign wr_insel[1] = sfr_wr && hit(sfr_addr, `CMP1_INSEL_ADDR);

    // ************************************************************
    // channels
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : ch
            cmp_sync u_sync
            (
                .core_clk   (core_clk),
                .rst_sync_n (rst_sync_n),
                .async_in   (analog_decision[g]),
                .sync_out   (sync_dec[g])
            );
            cmp_channel u_chan
            (
                .core_clk      (core_clk),
                .rst_sync_n    (rst_sync_n),
                .raw_decision  (analog_decision[g]),
                .sync_decision (sync_dec[g]),
                .wr_ctl        (wr_ctl[g]),
                .wr_mode       (wr_mode[g]),
                .wr_insel      (wr_insel[g]),
                .wr_data       (sfr_wdata),
                .ctl_rd        (ctl_rd[g]),
                .mode_rd       (mode_rd[g]),
                .insel_rd      (insel_rd[g]),
                .irq_req       (irq_req[g]),
                .latched_next  (latched_next[g]),
                .raw_gated     (raw_gated[g])
            );
        end
    endgenerate

    // ************************************************************
    // read port
    // ************************************************************
    always_comb
    begin
        case (sfr_addr)
            `CMP0_CONTROL_ADDR: rd_mux = ctl_rd[0];
            `CMP0_MODE_ADDR:    rd_mux = mode_rd[0];
            `CMP0_INSEL_ADDR:   rd_mux = insel_rd[0];
            `CMP1_CONTROL_ADDR: rd_mux = ctl_rd[1];
            `CMP1_MODE_ADDR:    rd_mux = mode_rd[1];
            `CMP1_INSEL_ADDR:   rd_mux = insel_rd[1];
            default:            rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            sfr_rdata <= 8'h00;
        else if (sfr_rd)
            sfr_rdata <= rd_mux;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            latched_cmp_out <= 2'b00;
            cmp_irq         <= 2'b00;
            cmp0_reset_src  <= 1'b0;
        end
        else
        begin
            latched_cmp_out <= latched_next;
            cmp_irq         <= irq_req;
            cmp0_reset_src  <= latched_next[0];
        end
    end

    // the raw path must survive a stopped clock, so it bypasses every flop by design;
    // a flop here would break stop-mode wakeup
    assign raw_cmp_out = raw_gated;
    assign pin_cmp_out = (pin_async_sel & raw_gated) | (~pin_async_sel & latched_cmp_out);

    a_latched_disabled: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        !ctl_rd[0][`CTL_EN_BIT] |=> !latched_cmp_out[0])
        else $error("disabled comparator drives high");
    a_out_bit_sync: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        ctl_rd[1][`CTL_OUT_BIT] == $past(analog_decision[1], 2))
        else $error("state bit not two-stage synchronised");
    a_ctl_reset: assert property (@(posedge core_clk) $rose(rst_sync_n) |-> ctl_rd[0] == `CTL_RESET)
        else $error("control reset value wrong");
endmodule

// >>> verif/tb.sv
// self-checking testbench of the dual comparator control block
`timescale 1ns/1ps
`include "cmp_ctrl_defs.svh"
module tb;
    logic       core_clk;
    logic       rst_n;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_rdata;
    logic [1:0] analog_decision;
    logic [1:0] pin_async_sel;
    logic [1:0] latched_cmp_out;
    logic [1:0] raw_cmp_out;
    logic [1:0] pin_cmp_out;
    logic [1:0] cmp_irq;
    logic       cmp0_reset_src;
    logic       rd_d;
    logic [7:0] d;
    logic [7:0] exp_q[$];
    int         miscompares;
    int         n_checks;
    int         seed;
    logic [7:0] ctl_a[2]   = '{`CMP0_CONTROL_ADDR, `CMP1_CONTROL_ADDR};
    logic [7:0] mode_a[2]  = '{`CMP0_MODE_ADDR, `CMP1_MODE_ADDR};
    logic [7:0] insel_a[2] = '{`CMP0_INSEL_ADDR, `CMP1_INSEL_ADDR};

    dual_comparator_control dut_u
    (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .sfr_addr        (sfr_addr),
        .sfr_wdata       (sfr_wdata),
        .sfr_wr          (sfr_wr),
        .sfr_rd          (sfr_rd),
        .sfr_rdata       (sfr_rdata),
        .analog_decision (analog_decision),
        .pin_async_sel   (pin_async_sel),
        .latched_cmp_out (latched_cmp_out),
        .raw_cmp_out     (raw_cmp_out),
        .pin_cmp_out     (pin_cmp_out),
        .cmp_irq         (cmp_irq),
        .cmp0_reset_src  (cmp0_reset_src)
    );

    // ****************************************
    // clock, checks and closing
    // ****************************************
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        chk({7'h00, got}, {7'h00, exp}, what);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // read data lands one edge after the strobe, so the oldest note is due then
    always @(posedge core_clk) rd_d <= sfr_rd;
    always @(negedge core_clk)
    begin
        if (rd_d === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                miscompares++;
                $display("ERROR %0t read with no note", $time);
            end
            else
                chk(sfr_rdata, exp_q.pop_front(), "read data");
        end
    end

    initial
    begin
        #200000;
        miscompares++;
        test_done();
    end

    // ****************************************
    // register port tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        exp_q.push_back(e);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge core_clk);
        sfr_rd = 1'b0;
    endtask

    // first access only once the internal reset copy has let go
    task automatic do_reset;
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(3);
    endtask

    task automatic reset_vals;
        for (int c = 0; c < 2; c++)
        begin
            rd(ctl_a[c], `CTL_RESET);
            rd(mode_a[c], `MODE_RESET);
            rd(insel_a[c], `INSEL_RESET);
        end
        rd(8'h99, 8'h00);
        $display("reset value test done");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        seed = 48141;
        rst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        analog_decision = 2'b00;
        pin_async_sel = 2'b00;
        do_reset();
        reset_vals();
        for (int c = 0; c < 2; c++)
        begin
            // analog held low so the state bit reads zero here
            for (int m = 0; m < 4; m++)
            begin
                d = $random(seed);
                wr(ctl_a[c], d);
                rd(ctl_a[c], d & `CTL_RW_MASK);
                d = $random(seed);
                wr(mode_a[c], {d[7:2], m[1:0]});
                rd(mode_a[c], {d[7:2], m[1:0]} & `MODE_RW_MASK);
                d = $random(seed);
                wr(insel_a[c], d);
                rd(insel_a[c], d | `INSEL_FIXED_ONES);
            end
            wr(ctl_a[c], 8'h80);
            wr(mode_a[c], 8'h00);
            cyc(4);
            $display("register access test done");
            @(negedge core_clk);
            analog_decision[c] = 1'b1;
            #1;
            chk1(raw_cmp_out[c], 1'b1, "raw follows decision");
            pin_async_sel[c] = 1'b1;
            #1;
            chk1(pin_cmp_out[c], 1'b1, "pin shows raw");
            pin_async_sel[c] = 1'b0;
            #1;
            chk1(pin_cmp_out[c], 1'b0, "pin shows latched");
            cyc(5);
            chk1(latched_cmp_out[c], 1'b1, "latched output");
            chk1(pin_cmp_out[c], 1'b1, "pin latched high");
            if (c == 0)
                chk1(cmp0_reset_src, 1'b1, "reset source");
            rd(ctl_a[c], 8'hE0);
            chk1(cmp_irq[c], 1'b0, "irq masked");
            wr(mode_a[c], 8'h20);
            cyc(2);
            chk1(cmp_irq[c], 1'b1, "rise irq");
            @(negedge core_clk);
            analog_decision[c] = 1'b0;
            cyc(5);
            rd(ctl_a[c], 8'hB0);
            wr(mode_a[c], 8'h10);
            cyc(2);
            chk1(cmp_irq[c], 1'b1, "fall irq");
            wr(ctl_a[c], 8'h80);
            cyc(2);
            chk1(cmp_irq[c], 1'b0, "irq after clear");
            rd(ctl_a[c], 8'h80);
            $display("edge flag test done");
            // clear lands on the very edge that sets the rise flag
            @(negedge core_clk);
            analog_decision[c] = 1'b1;
            @(negedge core_clk);
            wr(ctl_a[c], 8'h80);
            rd(ctl_a[c], 8'hE0);
            wr(ctl_a[c], 8'h00);
            chk1(raw_cmp_out[c], 1'b0, "raw when disabled");
            cyc(3);
            chk1(latched_cmp_out[c], 1'b0, "latched when disabled");
            pin_async_sel[c] = 1'b1;
            #1;
            chk1(pin_cmp_out[c], 1'b0, "pin when disabled");
            analog_decision[c] = 1'b0;
            wr(mode_a[c], 8'h02);
            $display("enable test done");
        end
        wr(ctl_a[0], 8'h8F);
        wr(mode_a[1], 8'h33);
        do_reset();
        reset_vals();
        test_done();
    end
endmodule
